/* File: scih_top.v */
// Storage card IDE host controller: card-register port, control port and card pins.
//
// Summary of operation
// - Drive 11-bit address, 16-bit bidirectional data.
// - Drive selects, strobes, reset, power; sense inputs.
// - Forward offsets 0-7 and 14 to card.
// - Task-file register meanings differ for read/write.
// - Control register offsets 0,1; 2,3 reserved.
// - Reading card control clears pending presence interrupt.
// - Bit 0 reads card presence, read-only.
// - Bit 1 drives card power output.
// - Bit 2 holds card in reset.
// - Presence change raises interrupt when enabled.
// - Card interrupt forwarded when enabled.
// - Two separate active-high interrupt outputs.
// - Two memory-mapped agent ports.
// - True IDE mode, mode 0 strobe timing.
`timescale 1ns/1ps
`default_nettype none
`include "scih_defines.vh"

module scih_top (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire [3:0] i_tf_address,
    input wire i_tf_read,
    input wire i_tf_write,
    input wire [15:0] i_tf_writedata,
    output reg [15:0] o_tf_readdata,
    output wire o_tf_waitrequest,
    input wire [1:0] i_ctl_address,
    input wire i_ctl_read,
    input wire i_ctl_write,
    input wire [31:0] i_ctl_writedata,
    output reg [31:0] o_ctl_readdata,
    output reg [10:0] o_card_addr,
    input wire [15:0] i_card_data,
    output reg [15:0] o_card_data,
    output reg [15:0] o_card_data_oe_n,
    output reg [1:0] o_card_cs_n,
    output reg o_card_iord_n,
    output reg o_card_iowr_n,
    output wire o_card_mode_sel_n,
    output wire o_card_we_n,
    output reg o_card_reset_n,
    output wire o_card_rsvd,
    output reg o_card_power,
    input wire i_card_ready,
    input wire i_card_irq,
    input wire i_card_present,
    output reg o_presence_irq,
    output reg o_card_irq
);
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_SETUP = 3'd1;
    localparam ST_PULSE = 3'd2;
    localparam ST_WAITRDY = 3'd3;
    localparam ST_HOLD = 3'd4;
    localparam ST_RECOV = 3'd5;
    localparam ST_DONE = 3'd6;

    reg [2:0] state;
    reg [`SCIH_CNT_W-1:0] cnt;
    reg is_write;
    reg card_power_on;
    reg card_reset_hold;
    reg presence_irq_enable;
    reg card_irq_enable;
    reg present_d;
    wire present_s;
    wire card_irq_s;
    wire [15:0] data_s;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    scih_sync u_sync_present (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_card_present),
        .o_sync(present_s)
    );
    scih_sync u_sync_irq (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_card_irq),
        .o_sync(card_irq_s)
    );

    wire ready_s;
    scih_sync u_sync_ready (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_card_ready),
        .o_sync(ready_s)
    );

    // Data is only captured after the strobe has been low for the full pulse
    // and ready has been seen, so it is stable when sampled past two flops.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_dsync
            scih_sync u_dsync (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_async(i_card_data[gi]),
                .o_sync(data_s[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Fixed card pins: true IDE mode, word-wide strobes only.
    // ------------------------------------------------------------------------
    assign o_card_mode_sel_n = 1'b0;
    assign o_card_we_n = 1'b1;
    assign o_card_rsvd = 1'b0;

    // ------------------------------------------------------------------------
    // Card-register port sequencer
    // ------------------------------------------------------------------------
    wire tf_req = i_tf_read | i_tf_write;
    wire tf_mapped = (i_tf_address <= `SCIH_TF_LAST_PRIMARY) ||
        (i_tf_address == `SCIH_TF_ALT_STATUS);
    // Unmapped offsets complete at once with zero data rather than hanging.
    assign o_tf_waitrequest = tf_req & ~((state == ST_DONE) | (state == ST_IDLE & ~tf_mapped));

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            cnt <= {`SCIH_CNT_W{1'b0}};
            is_write <= 1'b0;
            o_tf_readdata <= 16'h0000;
            o_card_addr <= 11'h000;
            o_card_data <= 16'h0000;
            o_card_data_oe_n <= 16'hffff;
            o_card_cs_n <= `SCIH_CS_IDLE;
            o_card_iord_n <= 1'b1;
            o_card_iowr_n <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (tf_req && tf_mapped) begin
                        is_write <= i_tf_write;
                        // Offset 14 is the alternate bank: secondary select, low address 6.
                        if (i_tf_address == `SCIH_TF_ALT_STATUS) begin
                            o_card_cs_n <= `SCIH_CS_SECONDARY;
                            o_card_addr <= {8'h00, `SCIH_ALT_LOW_ADDR};
                        end else begin
                            o_card_cs_n <= `SCIH_CS_PRIMARY;
                            o_card_addr <= {8'h00, i_tf_address[2:0]};
                        end
                        o_card_data <= i_tf_writedata;
                        o_card_data_oe_n <= i_tf_write ? 16'h0000 : 16'hffff;
                        cnt <= `SCIH_CYC_SETUP;
                        state <= ST_SETUP;
                    end else if (tf_req) begin
                        o_tf_readdata <= 16'h0000;
                    end
                end
                ST_SETUP: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        o_card_iord_n <= is_write;
                        o_card_iowr_n <= ~is_write;
                        cnt <= `SCIH_CYC_PULSE;
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        state <= ST_WAITRDY;
                    end
                end
                ST_WAITRDY: begin
                    if (ready_s) begin
                        o_tf_readdata <= data_s;
                        o_card_iord_n <= 1'b1;
                        o_card_iowr_n <= 1'b1;
                        cnt <= `SCIH_CYC_HOLD;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        o_card_cs_n <= `SCIH_CS_IDLE;
                        o_card_data_oe_n <= 16'hffff;
                        cnt <= `SCIH_CYC_RECOVER;
                        state <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (cnt > 1) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Clearing here lets an unmapped read, answered from idle, return zero.
                    o_tf_readdata <= 16'h0000;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Control port registers and interrupts
    // ------------------------------------------------------------------------
    wire rd_card_ctl = i_ctl_read && (i_ctl_address == `SCIH_CTL_CARD_CONTROL);
    wire wr_card_ctl = i_ctl_write && (i_ctl_address == `SCIH_CTL_CARD_CONTROL);
    wire wr_tf_ctl = i_ctl_write && (i_ctl_address == `SCIH_CTL_TASK_FILE_CONTROL);
    wire presence_event = presence_irq_enable && (present_s != present_d);

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            card_power_on <= 1'b0;
            card_reset_hold <= 1'b1;
            presence_irq_enable <= 1'b0;
            card_irq_enable <= 1'b0;
            present_d <= 1'b0;
            o_presence_irq <= 1'b0;
            o_card_irq <= 1'b0;
            o_card_power <= 1'b0;
            o_card_reset_n <= 1'b0;
            o_ctl_readdata <= 32'h0000_0000;
        end else begin
            present_d <= present_s;
            if (wr_card_ctl) begin
                card_power_on <= i_ctl_writedata[`SCIH_BIT_POWER];
                card_reset_hold <= i_ctl_writedata[`SCIH_BIT_RESET];
                presence_irq_enable <= i_ctl_writedata[`SCIH_BIT_PRES_IRQ_EN];
            end
            if (wr_tf_ctl) begin
                card_irq_enable <= i_ctl_writedata[`SCIH_BIT_CARD_IRQ_EN];
            end
            o_card_power <= card_power_on;
            o_card_reset_n <= ~card_reset_hold;
            // A new presence change in the read cycle wins over the clear.
            if (presence_event) begin
                o_presence_irq <= 1'b1;
            end else if (rd_card_ctl) begin
                o_presence_irq <= 1'b0;
            end
            // The card's line is a level; it follows the card while enabled.
            o_card_irq <= card_irq_enable & card_irq_s;
            o_ctl_readdata <= 32'h0000_0000;
            if (i_ctl_read) begin
                case (i_ctl_address)
                    `SCIH_CTL_CARD_CONTROL: begin
                        o_ctl_readdata <= {28'h000_0000, presence_irq_enable, card_reset_hold,
                            card_power_on, present_s};
                    end
                    `SCIH_CTL_TASK_FILE_CONTROL: begin
                        o_ctl_readdata <= {31'h0000_0000, card_irq_enable};
                    end
                    default: begin
                        o_ctl_readdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule // scih_top

`default_nettype wire

/* File: scih_defines.vh */
// Constants for the storage card IDE host controller.
`ifndef SCIH_DEFINES_VH
`define SCIH_DEFINES_VH

// ----------------------------------------------------------------------------
// Control port register offsets
// ----------------------------------------------------------------------------
`define SCIH_CTL_CARD_CONTROL 2'h0
`define SCIH_CTL_TASK_FILE_CONTROL 2'h1

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCIH_BIT_PRESENT 0
`define SCIH_BIT_POWER 1
`define SCIH_BIT_RESET 2
`define SCIH_BIT_PRES_IRQ_EN 3
`define SCIH_BIT_CARD_IRQ_EN 0

// ----------------------------------------------------------------------------
// Card-register port decode
// ----------------------------------------------------------------------------
`define SCIH_TF_LAST_PRIMARY 4'h7
`define SCIH_TF_ALT_STATUS 4'he
`define SCIH_CS_PRIMARY 2'h2
`define SCIH_CS_SECONDARY 2'h1
`define SCIH_CS_IDLE 2'h3
`define SCIH_ALT_LOW_ADDR 3'h6

// ----------------------------------------------------------------------------
// Strobe timing, mode 0 cycle, in ns at an 8 ns clock
// ----------------------------------------------------------------------------
`define SCIH_CLK_PERIOD_NS 8
`define SCIH_T_SETUP_NS 70
`define SCIH_T_PULSE_NS 165
`define SCIH_T_CYCLE_NS 600
`define SCIH_T_HOLD_NS 30
// Cycle counts are the times above rounded up to whole clocks (recovery is the cycle less setup and pulse), sized to the counter.
`define SCIH_CYC_SETUP 7'h09
`define SCIH_CYC_PULSE 7'h15
`define SCIH_CYC_RECOVER 7'h2e
`define SCIH_CYC_HOLD 7'h04
`define SCIH_CNT_W 7

`endif

/* File: scih_sync.v */
// Two-flop synchroniser for one level input.
`timescale 1ns/1ps
`default_nettype none

module scih_sync (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_async,
    output reg o_sync
);
    reg meta;

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule // scih_sync

`default_nettype wire

/* File: scih_assertions.sv */
// Port-level checks for the storage card IDE host controller.
`timescale 1ns/1ps
`default_nettype none

module scih_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_tf_address,
    input wire logic i_tf_read,
    input wire logic i_tf_write,
    input wire logic o_tf_waitrequest,
    input wire logic [1:0] i_ctl_address,
    input wire logic i_ctl_read,
    input wire logic i_ctl_write,
    input wire logic [31:0] i_ctl_writedata,
    input wire logic [31:0] o_ctl_readdata,
    input wire logic [1:0] o_card_cs_n,
    input wire logic o_card_iord_n,
    input wire logic o_card_iowr_n,
    input wire logic o_card_reset_n,
    input wire logic o_card_power,
    input wire logic i_card_irq,
    input wire logic o_card_irq,
    input wire logic i_card_present,
    input wire logic o_presence_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic wr0 = i_ctl_write && i_ctl_address == 2'h0;
    wire logic rd0 = i_ctl_read && i_ctl_address == 2'h0;
    wire logic strobe = !o_card_iord_n || !o_card_iowr_n;
    sequence irq_quiet; !i_card_irq [*4]; endsequence
    sequence pres_quiet; $stable(i_card_present) [*5]; endsequence
    a_power_follow: assert property (
        wr0 |-> ##2 o_card_power == $past(i_ctl_writedata[1], 2)) else $error("power pin wrong");
    a_reset_follow: assert property (
        wr0 |-> ##2 o_card_reset_n == !$past(i_ctl_writedata[2], 2)) else $error("reset pin wrong");
    a_rsvd_reads_zero: assert property (
        i_ctl_read && i_ctl_address[1] |=> o_ctl_readdata == 32'h0000_0000) else $error("rsvd read");
    a_upper_bits_zero: assert property (
        rd0 |=> o_ctl_readdata[31:4] == 28'h000_0000) else $error("upper bits set");
    a_strobe_held_wait: assert property (
        strobe |-> o_card_cs_n != 2'h3 && o_tf_waitrequest) else $error("strobe outside access");
    a_unmapped_quick: assert property (
        (i_tf_read || i_tf_write) && i_tf_address[3] && i_tf_address != 4'he
        |-> !o_tf_waitrequest) else $error("unmapped access stalled");
    a_card_irq_quiet: assert property (
        irq_quiet |-> !o_card_irq) else $error("card irq without cause");
    a_read_clears_irq: assert property (
        pres_quiet ##0 rd0 |=> !o_presence_irq) else $error("irq not cleared by read");
endmodule // scih_checker

`default_nettype wire

/* File: scih_card_model.sv */
// Behavioural storage card answering task-file accesses on the card pins.
`timescale 1ns/1ps
`default_nettype none

module scih_card_model (
    input wire logic i_ref_clk,
    input wire logic [10:0] i_addr,
    input wire logic [1:0] i_cs_n,
    input wire logic i_iord_n,
    input wire logic i_iowr_n,
    input wire logic [15:0] i_host_data,
    input wire logic [15:0] i_host_oe_n,
    input wire logic [7:0] i_delay,
    output logic [15:0] o_bus,
    output logic o_ready,
    output logic [15:0] o_wdata,
    output logic [10:0] o_waddr,
    output logic [1:0] o_wcs_n,
    output int o_writes
);
    logic [15:0] regs [0:15];
    logic [15:0] drive = 16'h0000;
    logic [7:0] held = 8'h00;
    logic wr_q = 1'b1;
    wire logic [3:0] idx = {~i_cs_n[1], i_addr[2:0]};
    wire logic strobe = !i_iord_n || !i_iowr_n;
    // A released bus flips every cycle, so stale data never passes for an answer.
    assign o_bus = (~i_host_oe_n & i_host_data) | (i_host_oe_n & drive);
    assign o_ready = !strobe || held >= i_delay;
    initial o_writes = 0;
    always @(posedge i_ref_clk) begin
        drive <= (!i_iord_n && i_cs_n != 2'h3) ? regs[idx] : ~drive;
        held <= strobe ? held + 8'h01 : 8'h00;
        wr_q <= i_iowr_n;
        if (!wr_q && i_iowr_n) begin
            regs[idx] <= o_bus;
            o_wdata <= o_bus;
            o_waddr <= i_addr;
            o_wcs_n <= i_cs_n;
            o_writes <= o_writes + 1;
        end
    end
endmodule // scih_card_model

`default_nettype wire

/* File: scih_top_tb.sv */
// Self-checking testbench for the storage card IDE host controller.
`timescale 1ns/1ps
`default_nettype none

module scih_top_tb;
    logic clk = 1'b0, rst_b = 1'b0, tf_rd = 1'b0, tf_wr = 1'b0, ctl_rd = 1'b0, ctl_wr = 1'b0;
    logic card_irq = 1'b0, present = 1'b1, ctl_seen = 1'b0, en;
    logic [3:0] tf_a = 4'h0, a;
    logic [15:0] tf_wd = 16'h0000, d;
    logic [1:0] ctl_a = 2'h0;
    logic [31:0] ctl_wd = 32'h0000_0000;
    logic [7:0] dly = 8'h00;
    logic [15:0] tf_rdata, c_data, c_oe_n, c_bus, m_wd;
    logic [31:0] ctl_rdata;
    logic [10:0] c_addr, m_addr;
    logic [1:0] c_cs_n, m_cs;
    logic wait_req, iord_n, iowr_n, reset_n, power, ready, pres_irq, c_irq;
    logic mode_n, we_n, rsvd;
    int mismatches = 0, checked = 0, m_writes, n0;
    string q_name [$];
    logic [31:0] q_exp [$];

    scih_top scih_top_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_tf_address(tf_a),
        .i_tf_read(tf_rd), .i_tf_write(tf_wr), .i_tf_writedata(tf_wd),
        .o_tf_readdata(tf_rdata), .o_tf_waitrequest(wait_req), .i_ctl_address(ctl_a),
        .i_ctl_read(ctl_rd), .i_ctl_write(ctl_wr), .i_ctl_writedata(ctl_wd),
        .o_ctl_readdata(ctl_rdata), .o_card_addr(c_addr), .i_card_data(c_bus),
        .o_card_data(c_data), .o_card_data_oe_n(c_oe_n), .o_card_cs_n(c_cs_n),
        .o_card_iord_n(iord_n), .o_card_iowr_n(iowr_n), .o_card_mode_sel_n(mode_n),
        .o_card_we_n(we_n), .o_card_reset_n(reset_n), .o_card_rsvd(rsvd), .o_card_power(power),
        .i_card_ready(ready), .i_card_irq(card_irq), .i_card_present(present),
        .o_presence_irq(pres_irq), .o_card_irq(c_irq));
    scih_card_model scih_card_model_i (.i_ref_clk(clk), .i_addr(c_addr), .i_cs_n(c_cs_n),
        .i_iord_n(iord_n), .i_iowr_n(iowr_n), .i_host_data(c_data), .i_host_oe_n(c_oe_n),
        .i_delay(dly), .o_bus(c_bus), .o_ready(ready), .o_wdata(m_wd), .o_waddr(m_addr),
        .o_wcs_n(m_cs), .o_writes(m_writes));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic note(input string name, input logic [31:0] v);
        q_name.push_back(name);
        q_exp.push_back(v);
    endtask

    task automatic ctl_go(input logic wr, input logic [1:0] ad, input logic [31:0] v);
        @(negedge clk);
        ctl_a = ad;
        ctl_wd = v;
        ctl_wr = wr;
        ctl_rd = !wr;
        @(negedge clk);
        ctl_wr = 1'b0;
        ctl_rd = 1'b0;
    endtask

    task automatic tf_go(input logic wr, input logic [3:0] ad, input logic [15:0] v);
        int n;
        @(negedge clk);
        tf_a = ad;
        tf_wd = v;
        tf_wr = wr;
        tf_rd = !wr;
        n = 0;
        #1;
        while (wait_req !== 1'b0 && n < 400) begin
            @(negedge clk);
            #1;
            n++;
        end
        if (n == 400) chk("tf_done", 1, 0);
        @(posedge clk);
        @(negedge clk);
        tf_rd = 1'b0;
        tf_wr = 1'b0;
    endtask

    task automatic close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Read results are matched in order against the notes the driver left.
    always @(posedge clk) ctl_seen <= ctl_rd;
    always @(negedge clk) begin
        #1;
        if (ctl_seen || (tf_rd && wait_req === 1'b0))
            chk(q_name.pop_front(), q_exp.pop_front(),
                ctl_seen ? ctl_rdata : {16'h0000, tf_rdata});
    end

    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    initial begin
        void'($urandom(32'hc0e1));
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        chk("reset_n", 0, reset_n);
        chk("power", 0, power);
        chk("mode_sel_n", 0, mode_n);
        chk("we_n", 1, we_n);
        chk("rsvd", 0, rsvd);
        // The presence bit needs two clocks through its synchroniser after reset.
        repeat (2) @(negedge clk);
        note("ctl0", 32'h0000_0005);
        ctl_go(0, 2'h0, 0);
        ctl_go(1, 2'h0, 32'hffff_fff2);
        repeat (2) @(negedge clk);
        chk("power", 1, power);
        chk("reset_n", 1, reset_n);
        note("ctl0", 32'h0000_0003);
        ctl_go(0, 2'h0, 0);
        ctl_go(1, 2'h1, 32'h0000_0001);
        note("ctl1", 32'h0000_0001);
        ctl_go(0, 2'h1, 0);
        for (int r = 2; r < 4; r++) begin
            ctl_go(1, r[1:0], $urandom);
            note("rsvd", 0);
            ctl_go(0, r[1:0], 0);
        end
        for (int i = 0; i < 9; i++) begin
            a = (i == 8) ? 4'he : i[3:0];
            d = 16'($urandom);
            dly = 8'($urandom % 40);
            tf_go(1, a, d);
            chk("cs_n", (i == 8) ? 2'h1 : 2'h2, m_cs);
            chk("addr", (i == 8) ? 11'h006 : {8'h00, a[2:0]}, m_addr);
            chk("wdata", d, m_wd);
            note("tf", d);
            tf_go(0, a, 0);
        end
        note("unmapped_rd", 0);
        tf_go(0, 4'h9, 16'h0000);
        n0 = m_writes;
        tf_go(1, 4'h9, 16'h1234);
        chk("unmapped", n0, m_writes);
        for (int e = 1; e >= 0; e--) begin
            ctl_go(1, 2'h1, e);
            card_irq = 1'b1;
            repeat (6) @(negedge clk);
            chk("card_irq", e, c_irq);
            card_irq = 1'b0;
            repeat (6) @(negedge clk);
        end
        for (int k = 0; k < 3; k++) begin
            en = (k < 2);
            ctl_go(1, 2'h0, {28'h000_0000, en, 3'h2});
            present = !present;
            repeat (6) @(negedge clk);
            chk("pres_irq", en, pres_irq);
            note("ctl0", {28'h000_0000, en, 2'h1, present});
            ctl_go(0, 2'h0, 0);
            chk("pres_irq", 0, pres_irq);
        end
        close_out();
    end
endmodule // scih_top_tb

bind scih_top scih_checker scih_checker_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_tf_address(i_tf_address), .i_tf_read(i_tf_read), .i_tf_write(i_tf_write),
    .o_tf_waitrequest(o_tf_waitrequest), .i_ctl_address(i_ctl_address),
    .i_ctl_read(i_ctl_read), .i_ctl_write(i_ctl_write), .i_ctl_writedata(i_ctl_writedata),
    .o_ctl_readdata(o_ctl_readdata), .o_card_cs_n(o_card_cs_n), .o_card_iord_n(o_card_iord_n),
    .o_card_iowr_n(o_card_iowr_n), .o_card_reset_n(o_card_reset_n), .o_card_power(o_card_power),
    .i_card_irq(i_card_irq), .o_card_irq(o_card_irq), .i_card_present(i_card_present),
    .o_presence_irq(o_presence_irq));

`default_nettype wire
